// [etf_pkg.sv]
`default_nettype none
package etf_pkg;
	localparam logic [7:0] DELIM = 8'h7E;
	localparam logic [7:0] TYPE_EXPLICIT_TX = 8'h11;
	localparam logic [7:0] TYPE_TX_STATUS = 8'h8B;
	localparam logic [7:0] CKSUM_BASE = 8'hFF;
	localparam logic [7:0] CMD_READ_ATTR = 8'h00;
	localparam logic [1:0] FTYPE_GENERAL = 2'h0;
	localparam logic [7:0] MAX_HOPS_DEF = 8'h1E;
	localparam logic [15:0] OFS_FTYPE = 16'h0000;
	localparam logic [15:0] OFS_FID = 16'h0001;
	localparam logic [15:0] OFS_RADIUS = 16'h0012;
	localparam logic [15:0] OFS_OPTS = 16'h0013;
	localparam logic [15:0] OFS_FCTL = 16'h0014;
	localparam logic [15:0] OFS_TSN = 16'h0015;
	localparam logic [15:0] OFS_CMD = 16'h0016;
	localparam logic [15:0] MIN_LEN = 16'h0017;
	localparam logic [2:0] ST_LAST = 3'h5;
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] ADDR_INFO = 32'h0000_0008;
	localparam logic [31:0] ADDR_SEQ = 32'h0000_000C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ETF_HUNT = 3'h0,
		ETF_LEN_HI = 3'h1,
		ETF_LEN_LO = 3'h3,
		ETF_BODY = 3'h2,
		ETF_CKSUM = 3'h6,
		ETF_ST_SEND = 3'h7
	} etf_state_t;
	typedef struct packed {
		logic [7:0] fid;
		logic [7:0] radius;
		logic [7:0] fctl;
		logic [7:0] tsn;
		logic [7:0] cmd;
	} etf_hdr_t;
	typedef struct packed {
		logic [7:0] ok_cnt;
		logic [7:0] bad_cnt;
		logic api_output_option;
	} etf_stat_t;
endpackage : etf_pkg
`default_nettype wire

// [etf_framer.sv]
// Contract
// - Frame starts 0x7E, then two-byte big-endian length excluding checksum.
// - Offset 3 frame type; 0x11 marks explicit transmit request.
// - Frame ID echoed in transmit status; zero ID means no status.
// - Radius at offset 21; zero selects network maximum hop count.
// - Offset 24 sequence number returned by responder for pairing.
// - Offset 25 command id; type 00 general, 0x00 reads attributes.
// - Last byte is 0xFF minus low byte of sum from offset 3.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module etf_framer (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output logic frame_ok_o,
	output logic [7:0] hops_o,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	etf_pkg::etf_state_t state_ff;
	logic [15:0] len_ff;
	logic [15:0] idx_ff;
	logic [7:0] sum_ff;
	etf_pkg::etf_hdr_t hdr_ff;
	etf_pkg::etf_stat_t stat_ff;
	logic [7:0] max_hops_ff;
	logic [7:0] fid_ok_ff;
	logic [7:0] tsn_ok_ff;
	logic [7:0] cmd_ok_ff;
	logic [7:0] rad_ok_ff;
	logic [7:0] tx_data_ff;
	logic [2:0] st_idx_ff;
	logic read_attr_ff;
	logic frame_ok_ff;
	logic take;
	logic [7:0] nxt_sum;
	logic [7:0] st_byte;
	logic [7:0] st_ck;
	logic type_seen_ff;
	logic good;
	logic aw_hit;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] bresp_ff;
	logic [1:0] rresp_ff;

	// Byte stream is same-clock logic; stall input while a status frame drains
	assign rx_ready_o = (state_ff != etf_pkg::ETF_ST_SEND);
	assign take = rx_valid_i && rx_ready_o;
	assign nxt_sum = sum_ff + rx_data_i;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_ff <= etf_pkg::ETF_HUNT;
			len_ff <= 16'h0000;
			idx_ff <= 16'h0000;
			sum_ff <= 8'h00;
			hdr_ff <= '0;
		end else if (take) begin
			unique case (state_ff)
				etf_pkg::ETF_HUNT: begin
					if (rx_data_i == etf_pkg::DELIM) state_ff <= etf_pkg::ETF_LEN_HI;
				end
				etf_pkg::ETF_LEN_HI: begin
					len_ff[15:8] <= rx_data_i;
					state_ff <= etf_pkg::ETF_LEN_LO;
				end
				etf_pkg::ETF_LEN_LO: begin
					len_ff[7:0] <= rx_data_i;
					idx_ff <= 16'h0000;
					sum_ff <= 8'h00;
					// Too short to hold the header: drop and rescan
					state_ff <= ({len_ff[15:8], rx_data_i} < etf_pkg::MIN_LEN) ?
						etf_pkg::ETF_HUNT : etf_pkg::ETF_BODY;
				end
				etf_pkg::ETF_BODY: begin
					sum_ff <= nxt_sum;
					idx_ff <= idx_ff + 16'h0001;
					unique case (idx_ff)
						etf_pkg::OFS_FID: hdr_ff.fid <= rx_data_i;
						etf_pkg::OFS_RADIUS: hdr_ff.radius <= rx_data_i;
						etf_pkg::OFS_FCTL: hdr_ff.fctl <= rx_data_i;
						etf_pkg::OFS_TSN: hdr_ff.tsn <= rx_data_i;
						etf_pkg::OFS_CMD: hdr_ff.cmd <= rx_data_i;
						default: ;
					endcase
					if (idx_ff == len_ff - 16'h0001) state_ff <= etf_pkg::ETF_CKSUM;
				end
				etf_pkg::ETF_CKSUM: begin
					// Status only for a good explicit frame with nonzero id
					if (good && hdr_ff.fid != 8'h00)
						state_ff <= etf_pkg::ETF_ST_SEND;
					else
						state_ff <= etf_pkg::ETF_HUNT;
				end
				default: state_ff <= etf_pkg::ETF_HUNT;
			endcase
		end else if (state_ff == etf_pkg::ETF_ST_SEND && tx_ready_i
			&& st_idx_ff == etf_pkg::ST_LAST) begin
			// Leave only once the checksum byte has been accepted
			state_ff <= etf_pkg::ETF_HUNT;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			type_seen_ff <= 1'b0;
		else if (take && state_ff == etf_pkg::ETF_BODY && idx_ff == etf_pkg::OFS_FTYPE)
			type_seen_ff <= (rx_data_i == etf_pkg::TYPE_EXPLICIT_TX);
	end

	assign good = take && state_ff == etf_pkg::ETF_CKSUM &&
		(etf_pkg::CKSUM_BASE - sum_ff) == rx_data_i && type_seen_ff;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			stat_ff <= '0;
			fid_ok_ff <= 8'h00;
			tsn_ok_ff <= 8'h00;
			cmd_ok_ff <= 8'h00;
			rad_ok_ff <= 8'h00;
			read_attr_ff <= 1'b0;
			frame_ok_ff <= 1'b0;
		end else begin
			frame_ok_ff <= good;
			if (good) begin
				stat_ff.ok_cnt <= stat_ff.ok_cnt + 8'h01;
				fid_ok_ff <= hdr_ff.fid;
				tsn_ok_ff <= hdr_ff.tsn;
				cmd_ok_ff <= hdr_ff.cmd;
				// Zero radius falls back to the network maximum
				rad_ok_ff <= (hdr_ff.radius == 8'h00) ? max_hops_ff : hdr_ff.radius;
				read_attr_ff <= (hdr_ff.fctl[1:0] == etf_pkg::FTYPE_GENERAL) &&
					(hdr_ff.cmd == etf_pkg::CMD_READ_ATTR);
			end else if (take && state_ff == etf_pkg::ETF_CKSUM) begin
				stat_ff.bad_cnt <= stat_ff.bad_cnt + 8'h01;
			end
			if (aw_hit && s_axi_awaddr == etf_pkg::ADDR_CTRL && s_axi_wstrb[0])
				stat_ff.api_output_option <= s_axi_wdata[0];
		end
	end

	// Status frame 7E 00 02 type id checksum; the delimiter is preloaded,
	// so the table gives the byte that follows the one now on the line
	always_comb begin
		st_ck = etf_pkg::CKSUM_BASE - (etf_pkg::TYPE_TX_STATUS + fid_ok_ff);
		unique case (st_idx_ff)
			3'h0: st_byte = 8'h00;
			3'h1: st_byte = 8'h02;
			3'h2: st_byte = etf_pkg::TYPE_TX_STATUS;
			3'h3: st_byte = fid_ok_ff;
			default: st_byte = st_ck;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_idx_ff <= 3'h0;
			tx_data_ff <= 8'h00;
		end else if (state_ff != etf_pkg::ETF_ST_SEND) begin
			st_idx_ff <= 3'h0;
			tx_data_ff <= etf_pkg::DELIM;
		end else if (tx_ready_i) begin
			st_idx_ff <= st_idx_ff + 3'h1;
			tx_data_ff <= st_byte;
		end
	end
	// Input stays stalled until the last status byte is gone
	assign tx_valid_o = (state_ff == etf_pkg::ETF_ST_SEND);
	assign tx_data_o = tx_data_ff;
	assign frame_ok_o = frame_ok_ff;
	assign hops_o = rad_ok_ff;

	// AXI4-Lite slave: one write, one read at a time
	assign aw_hit = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign s_axi_awready = aw_hit;
	assign s_axi_wready = aw_hit;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = s_axi_arvalid && !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= etf_pkg::RESP_OKAY;
			max_hops_ff <= etf_pkg::MAX_HOPS_DEF;
		end else if (aw_hit) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (s_axi_awaddr == etf_pkg::ADDR_CTRL) ? etf_pkg::RESP_OKAY :
				etf_pkg::RESP_SLVERR;
			if (s_axi_awaddr == etf_pkg::ADDR_CTRL && s_axi_wstrb[1])
				max_hops_ff <= s_axi_wdata[15:8];
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= etf_pkg::RESP_OKAY;
		end else if (s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= etf_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				etf_pkg::ADDR_CTRL: rdata_ff <= {16'h0000, max_hops_ff, 7'h00,
					stat_ff.api_output_option};
				etf_pkg::ADDR_STATUS: rdata_ff <= {15'h0000, read_attr_ff,
					stat_ff.bad_cnt, stat_ff.ok_cnt};
				etf_pkg::ADDR_INFO: rdata_ff <= {8'h00, rad_ok_ff, cmd_ok_ff, fid_ok_ff};
				etf_pkg::ADDR_SEQ: rdata_ff <= {24'h000000, tsn_ok_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= etf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule : etf_framer
`default_nettype wire

// [etf_framer_sva.sv]
`default_nettype none
module etf_framer_sva (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic rx_valid_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic frame_ok_o,
	input wire logic [7:0] hops_o,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence beat_s;
		tx_valid_o && tx_ready_i;
	endsequence
	start_byte_a: assert property ($rose(tx_valid_o) |-> tx_data_o == 8'h7E)
		else $error("status frame not opened by delimiter");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("status byte dropped while stalled");
	status_type_a: assert property (beat_s ##0 tx_data_o == 8'h7E |=> ##[0:60] beat_s ##0 tx_data_o == 8'h8B)
		else $error("status type byte missing");
	rx_block_a: assert property (tx_valid_o |-> !rx_ready_o)
		else $error("input open while status is sent");
	ok_pulse_a: assert property (frame_ok_o |=> !frame_ok_o)
		else $error("good frame flag longer than one cycle");
	ok_cause_a: assert property (frame_ok_o |-> $past(rx_valid_i && rx_ready_o))
		else $error("good frame flag without a taken byte");
	hops_set_a: assert property (frame_ok_o |-> hops_o != 8'h00)
		else $error("zero hop count reported");
	bresp_time_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
endmodule : etf_framer_sva
`default_nettype wire

// [etf_host_model.sv]
`default_nettype none
module etf_host_model (
	input wire logic sys_clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic rx_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'hA5;
	end
	// Read-attributes request to broadcast; flip corrupts the checksum, gap slows the host
	task automatic send(input logic [7:0] fid, rad, flip, input int gap);
		logic [7:0] f[$];
		logic [7:0] s;
		f = '{8'h11, fid, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
			8'hFF, 8'hFE, 8'h41, 8'h42, 8'h00, 8'h00, 8'hD1, 8'h23, rad, 8'h00,
			8'h00, 8'h01, 8'h00, 8'h03, 8'h00};
		s = 8'h00;
		foreach (f[i]) s += f[i];
		f.push_back((8'hFF - s) ^ flip);
		f = {8'h7E, 8'h00, 8'h19, f};
		rx_valid_o <= 1'b1;
		foreach (f[i]) begin
			rx_data_o <= f[i];
			do @(posedge sys_clk_i); while (rx_ready_i !== 1'b1);
			if (gap > 0 && i < f.size() - 1) begin
				rx_valid_o <= 1'b0;
				rx_data_o <= ~f[i];
				repeat (gap) @(posedge sys_clk_i);
				rx_valid_o <= 1'b1;
			end
		end
		rx_valid_o <= 1'b0;
		rx_data_o <= ~f[f.size() - 1];
	endtask : send
endmodule : etf_host_model
`default_nettype wire

// [test_explicit_tx_api_framer.sv]
`default_nettype none
module test_explicit_tx_api_framer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, rxv, rxr, txv, txr = 1'b0, ok;
	logic [7:0] rxd, txd, hops;
	logic [31:0] aw = '0, wd = '0, ar = '0, rdat;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv;
	logic [1:0] br, rr;
	logic [7:0] txq[$];
	int err_total = 0, check_count = 0;
	int ok_seen = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) txr <= ~txr;
	always @(posedge clk) if (txv === 1'b1 && txr === 1'b1) txq.push_back(txd);
	always @(posedge clk) if (ok === 1'b1) ok_seen++;
	etf_host_model host_u (.sys_clk_i(clk), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr));
	etf_framer dut_u (.sys_clk_i(clk), .rst_i(rst), .rx_valid_i(rxv), .rx_data_i(rxd),
		.rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr),
		.frame_ok_o(ok), .hops_o(hops), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
	task automatic chk(input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wrr(input logic [31:0] a, d);
		aw <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		do @(posedge clk); while (!(awr === 1'b1 && wr === 1'b1));
		awv <= 0;
		wv <= 0;
		// Late bready makes the response stall for a cycle
		@(posedge clk);
		bry <= 1;
		do @(posedge clk); while (bv !== 1'b1);
		bry <= 0;
		chk({30'h0, br}, 32'h0);
	endtask : wrr
	task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
		ar <= a;
		arv <= 1;
		rry <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1'b1);
		rry <= 0;
		chk(rdat, e);
		chk({30'h0, rr}, {30'h0, er});
	endtask : rd
	task automatic status_is(input logic [7:0] fid);
		logic [47:0] want;
		want = {8'h7E, 8'h00, 8'h02, 8'h8B, fid, 8'hFF - (8'h8B + fid)};
		chk(txq.size(), 6);
		for (int i = 0; i < 6; i++) chk(txq[i], want[47 - 8 * i -: 8]);
		txq.delete();
	endtask : status_is
	task automatic t_regs;
		rd(32'h0, 32'h00001E00, 2'h0);
		rd(32'h10, 32'h0, 2'h2);
		wrr(32'h0, 32'h00001E01);
		rd(32'h0, 32'h00001E01, 2'h0);
	endtask : t_regs
	task automatic t_good;
		host_u.send(8'h01, 8'h05, 8'h00, 0);
		repeat (40) @(posedge clk);
		status_is(8'h01);
		chk({24'h0, hops}, 32'h5);
		chk(ok_seen, 1);
		rd(32'h4, 32'h00010001, 2'h0);
		rd(32'hC, 32'h1, 2'h0);
	endtask : t_good
	task automatic t_zero;
		host_u.send(8'h00, 8'h00, 8'h00, 2);
		repeat (40) @(posedge clk);
		chk(txq.size(), 0);
		chk({24'h0, hops}, 32'h1E);
		chk(ok_seen, 2);
	endtask : t_zero
	task automatic t_bad;
		host_u.send(8'h03, 8'h07, 8'h01, 0);
		@(posedge clk);
		host_u.send(8'h04, 8'h09, 8'h00, 0);
		repeat (40) @(posedge clk);
		status_is(8'h04);
		chk({24'h0, hops}, 32'h9);
		chk(ok_seen, 3);
		rd(32'h4, 32'h00010103, 2'h0);
	endtask : t_bad
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_good();
		t_zero();
		t_bad();
		print_verdict();
	end
endmodule : test_explicit_tx_api_framer
bind etf_framer etf_framer_sva chk_u (.sys_clk_i, .rst_i, .rx_valid_i, .rx_ready_o, .tx_valid_o,
	.tx_data_o, .tx_ready_i, .frame_ok_o, .hops_o, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready);
`default_nettype wire
